// >>> rtl/fscr_regs.sv
// What this block does
// - Bits 7-6 of FIFO setup pick depth 16/32/48/64 bytes, reset 16.
// - Bits 5-0 of FIFO setup hold threshold fill level, reset 001111.
// - Threshold condition is one test in transmit mode and another shared by receive and standby.
// - Six counter registers are full 8-bit read/write divider counts.
// - Select bit 0 drives the synthesizer from set A only.
// - Select bit 1 drives the synthesizer from set B only.
// - Set A resets to 0x77, 0x64, 0x32.
// - Set B resets to 0x74, 0x62, 0x32.
//
// The APB interface to the registers was decided locally.
module fscr_regs
  import fscr_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic [6:0] i_fifo_fill,
  output logic [6:0] o_fifo_depth,
  output logic [5:0] o_fifo_level_trigger,
  output logic o_synth_set_select,
  output logic [7:0] o_synth_first_count,
  output logic [7:0] o_synth_second_count,
  output logic [7:0] o_synth_third_count,
  output logic [1:0] o_mode,
  output logic o_irq
);
  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  logic acc;
  logic wr;
  logic [5:0] idx;
  logic aligned;
  logic mapped;
  assign acc = i_psel && i_penable;
  assign idx = i_paddr[7:2];
  assign aligned = (i_paddr[1:0] == 2'h0);
  assign wr = acc && i_pwrite && mapped;
  assign o_pready = 1'b1;

  always_comb begin
    mapped = aligned;
    unique case ({2'h0, idx})
      IDX_FIFO_SETUP, IDX_SET_A_FIRST, IDX_SET_A_SECOND, IDX_SET_A_THIRD,
      IDX_SET_B_FIRST, IDX_SET_B_SECOND, IDX_SET_B_THIRD, IDX_CONTROL,
      IDX_IRQ_STATUS, IDX_IRQ_MASK, IDX_FIFO_LEVEL: mapped = aligned;
      default: mapped = 1'b0;
    endcase
  end

  assign o_pslverr = acc && !mapped;

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  logic [7:0] fifo_setup;
  logic [7:0] set_a_first_count;
  logic [7:0] set_a_second_count;
  logic [7:0] set_a_third_count;
  logic [7:0] set_b_first_count;
  logic [7:0] set_b_second_count;
  logic [7:0] set_b_third_count;

  fscr_reg8 #(.RESET_VALUE(RST_FIFO_SETUP)) u_fifo_setup (
    .i_core_clk(i_core_clk), .i_resetn(i_resetn),
    .i_wr(wr && ({2'h0, idx} == IDX_FIFO_SETUP)),
    .i_wdata(i_pwdata[7:0]), .o_q(fifo_setup));
  fscr_reg8 #(.RESET_VALUE(RST_SET_A_FIRST)) u_a1 (
    .i_core_clk(i_core_clk), .i_resetn(i_resetn),
    .i_wr(wr && ({2'h0, idx} == IDX_SET_A_FIRST)),
    .i_wdata(i_pwdata[7:0]), .o_q(set_a_first_count));
  fscr_reg8 #(.RESET_VALUE(RST_SET_A_SECOND)) u_a2 (
    .i_core_clk(i_core_clk), .i_resetn(i_resetn),
    .i_wr(wr && ({2'h0, idx} == IDX_SET_A_SECOND)),
    .i_wdata(i_pwdata[7:0]), .o_q(set_a_second_count));
  fscr_reg8 #(.RESET_VALUE(RST_SET_A_THIRD)) u_a3 (
    .i_core_clk(i_core_clk), .i_resetn(i_resetn),
    .i_wr(wr && ({2'h0, idx} == IDX_SET_A_THIRD)),
    .i_wdata(i_pwdata[7:0]), .o_q(set_a_third_count));
  fscr_reg8 #(.RESET_VALUE(RST_SET_B_FIRST)) u_b1 (
    .i_core_clk(i_core_clk), .i_resetn(i_resetn),
    .i_wr(wr && ({2'h0, idx} == IDX_SET_B_FIRST)),
    .i_wdata(i_pwdata[7:0]), .o_q(set_b_first_count));
  fscr_reg8 #(.RESET_VALUE(RST_SET_B_SECOND)) u_b2 (
    .i_core_clk(i_core_clk), .i_resetn(i_resetn),
    .i_wr(wr && ({2'h0, idx} == IDX_SET_B_SECOND)),
    .i_wdata(i_pwdata[7:0]), .o_q(set_b_second_count));
  fscr_reg8 #(.RESET_VALUE(RST_SET_B_THIRD)) u_b3 (
    .i_core_clk(i_core_clk), .i_resetn(i_resetn),
    .i_wr(wr && ({2'h0, idx} == IDX_SET_B_THIRD)),
    .i_wdata(i_pwdata[7:0]), .o_q(set_b_third_count));

  // ----------------------------------------
  // Control, set selection and synthesizer counts
  // ----------------------------------------
  logic synth_set_select;
  logic [1:0] mode;
  logic next_synth_set_select;
  logic [1:0] next_mode;
  logic [7:0] next_first;
  logic [7:0] next_second;
  logic [7:0] next_third;
  logic set_switch;

  always_comb begin
    next_synth_set_select = synth_set_select;
    next_mode = mode;
    if (wr && ({2'h0, idx} == IDX_CONTROL)) begin
      next_synth_set_select = i_pwdata[CTL_SET_SEL];
      next_mode = i_pwdata[CTL_MODE_MSB:CTL_MODE_LSB];
    end
    // One mux select for all three keeps the counts coherent
    if (synth_set_select) begin
      next_first = set_b_first_count;
      next_second = set_b_second_count;
      next_third = set_b_third_count;
    end else begin
      next_first = set_a_first_count;
      next_second = set_a_second_count;
      next_third = set_a_third_count;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      synth_set_select <= 1'b0;
      mode <= FSCR_MODE_STANDBY;
      o_synth_first_count <= RST_SET_A_FIRST;
      o_synth_second_count <= RST_SET_A_SECOND;
      o_synth_third_count <= RST_SET_A_THIRD;
    end else begin
      synth_set_select <= next_synth_set_select;
      mode <= next_mode;
      o_synth_first_count <= next_first;
      o_synth_second_count <= next_second;
      o_synth_third_count <= next_third;
    end
  end

  assign o_synth_set_select = synth_set_select;
  assign o_mode = mode;
  assign set_switch = (next_synth_set_select != synth_set_select);

  // ----------------------------------------
  // FIFO sizing and threshold
  // ----------------------------------------
  logic [1:0] depth_sel;
  logic [6:0] next_fifo_depth;
  logic thresh_level;
  logic thresh_level_d;
  assign depth_sel = fifo_setup[DEPTH_SEL_MSB:DEPTH_SEL_LSB];
  assign o_fifo_level_trigger = fifo_setup[TRIG_MSB:TRIG_LSB];

  always_comb begin
    unique case (depth_sel)
      2'h0: next_fifo_depth = DEPTH_16;
      2'h1: next_fifo_depth = DEPTH_32;
      2'h2: next_fifo_depth = DEPTH_48;
      2'h3: next_fifo_depth = DEPTH_64;
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_fifo_depth <= DEPTH_16;
    end else begin
      o_fifo_depth <= next_fifo_depth;
    end
  end

  fscr_thresh u_thresh (
    .i_core_clk(i_core_clk),
    .i_resetn(i_resetn),
    .i_mode(mode),
    .i_trigger(o_fifo_level_trigger),
    .i_fill(i_fifo_fill),
    .o_level(thresh_level));

  // ----------------------------------------
  // Interrupts
  // ----------------------------------------
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] irq_mask;
  logic [IRQ_W-1:0] next_irq_status;
  logic [IRQ_W-1:0] next_irq_mask;
  logic [IRQ_W-1:0] irq_event;

  always_comb begin
    irq_event = '0;
    irq_event[IRQ_THRESH] = thresh_level && !thresh_level_d;
    irq_event[IRQ_SET_SWITCH] = set_switch;
    next_irq_status = irq_status;
    next_irq_mask = irq_mask;
    if (wr && ({2'h0, idx} == IDX_IRQ_STATUS)) begin
      next_irq_status = irq_status & ~i_pwdata[IRQ_W-1:0];
    end
    if (wr && ({2'h0, idx} == IDX_IRQ_MASK)) begin
      next_irq_mask = i_pwdata[IRQ_W-1:0];
    end
    // Set wins over a simultaneous clear so no event is lost
    next_irq_status = next_irq_status | irq_event;
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      irq_status <= '0;
      irq_mask <= '0;
      thresh_level_d <= 1'b0;
    end else begin
      irq_status <= next_irq_status;
      irq_mask <= next_irq_mask;
      thresh_level_d <= thresh_level;
    end
  end

  assign o_irq = |(irq_status & irq_mask);

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  logic [31:0] next_prdata;

  // Loaded in the setup cycle so the data stands for the whole access phase
  always_comb begin
    next_prdata = o_prdata;
    if (i_psel && !i_penable) begin
      next_prdata = 32'h0000_0000;
      if (aligned) begin
        unique case ({2'h0, idx})
          IDX_FIFO_SETUP: next_prdata[7:0] = fifo_setup;
          IDX_SET_A_FIRST: next_prdata[7:0] = set_a_first_count;
          IDX_SET_A_SECOND: next_prdata[7:0] = set_a_second_count;
          IDX_SET_A_THIRD: next_prdata[7:0] = set_a_third_count;
          IDX_SET_B_FIRST: next_prdata[7:0] = set_b_first_count;
          IDX_SET_B_SECOND: next_prdata[7:0] = set_b_second_count;
          IDX_SET_B_THIRD: next_prdata[7:0] = set_b_third_count;
          IDX_CONTROL: next_prdata[2:0] = {mode, synth_set_select};
          IDX_IRQ_STATUS: next_prdata[IRQ_W-1:0] = irq_status;
          IDX_IRQ_MASK: next_prdata[IRQ_W-1:0] = irq_mask;
          IDX_FIFO_LEVEL: next_prdata[7:0] = {1'b0, i_fifo_fill};
          default: next_prdata = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_prdata <= 32'h0000_0000;
    end else begin
      o_prdata <= next_prdata;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  AST_SET_A_USED: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    !synth_set_select |=> o_synth_first_count == $past(set_a_first_count))
    else $error("first count not from set A");
  AST_SET_B_USED: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    synth_set_select |=> o_synth_third_count == $past(set_b_third_count))
    else $error("third count not from set B");
  AST_COHERENT: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    $past(synth_set_select) ?
      (o_synth_first_count == $past(set_b_first_count) &&
       o_synth_second_count == $past(set_b_second_count)) :
      (o_synth_first_count == $past(set_a_first_count) &&
       o_synth_second_count == $past(set_a_second_count)))
    else $error("synth counts mixed between sets");
  AST_DEPTH_64: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    depth_sel == 2'h3 |=> o_fifo_depth == DEPTH_64)
    else $error("depth code 3 not 64 bytes");
  AST_DEPTH_16: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    depth_sel == 2'h0 |=> o_fifo_depth == DEPTH_16)
    else $error("depth code 0 not 16 bytes");
  AST_TRIG_WRITE: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    wr && ({2'h0, idx} == IDX_FIFO_SETUP) |=> o_fifo_level_trigger == $past(i_pwdata[5:0]))
    else $error("trigger level not written");
  AST_COUNT_WRITE: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    wr && ({2'h0, idx} == IDX_SET_B_SECOND) |=> set_b_second_count == $past(i_pwdata[7:0]))
    else $error("counter register not written");
  AST_THRESH_TX: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    mode == FSCR_MODE_TX && i_fifo_fill <= {1'b0, o_fifo_level_trigger} |=> thresh_level)
    else $error("tx threshold not raised");
  AST_THRESH_RX: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    mode == FSCR_MODE_RX && i_fifo_fill > {1'b0, o_fifo_level_trigger} |=> thresh_level)
    else $error("rx threshold not raised");
  AST_THRESH_TX_LOW: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    mode == FSCR_MODE_TX && i_fifo_fill > {1'b0, o_fifo_level_trigger} |=> !thresh_level)
    else $error("tx threshold raised above trigger");
  AST_THRESH_IDLE_LOW: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    mode != FSCR_MODE_TX && i_fifo_fill <= {1'b0, o_fifo_level_trigger} |=> !thresh_level)
    else $error("rx or standby threshold raised at or below trigger");
  AST_SWITCH_FLAG: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    set_switch |=> irq_status[IRQ_SET_SWITCH])
    else $error("set switch not flagged");
  AST_IRQ_OUT: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    irq_event[IRQ_THRESH] && irq_mask[IRQ_THRESH] && !(wr && ({2'h0, idx} == IDX_IRQ_MASK))
    |=> o_irq)
    else $error("masked-in event did not raise irq");
endmodule : fscr_regs

// >>> common/fscr_pkg.sv
package fscr_pkg;
  // Printed offsets are register indices; byte address is four times the index
  localparam logic [7:0] IDX_FIFO_SETUP = 8'h05;
  localparam logic [7:0] IDX_SET_A_FIRST = 8'h06;
  localparam logic [7:0] IDX_SET_A_SECOND = 8'h07;
  localparam logic [7:0] IDX_SET_A_THIRD = 8'h08;
  localparam logic [7:0] IDX_SET_B_FIRST = 8'h09;
  localparam logic [7:0] IDX_SET_B_SECOND = 8'h0A;
  localparam logic [7:0] IDX_SET_B_THIRD = 8'h0B;
  localparam logic [7:0] IDX_CONTROL = 8'h10;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h11;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h12;
  localparam logic [7:0] IDX_FIFO_LEVEL = 8'h13;

  localparam logic [7:0] RST_FIFO_SETUP = 8'h0F;
  localparam logic [7:0] RST_SET_A_FIRST = 8'h77;
  localparam logic [7:0] RST_SET_A_SECOND = 8'h64;
  localparam logic [7:0] RST_SET_A_THIRD = 8'h32;
  localparam logic [7:0] RST_SET_B_FIRST = 8'h74;
  localparam logic [7:0] RST_SET_B_SECOND = 8'h62;
  localparam logic [7:0] RST_SET_B_THIRD = 8'h32;

  localparam int DEPTH_SEL_MSB = 7;
  localparam int DEPTH_SEL_LSB = 6;
  localparam int TRIG_MSB = 5;
  localparam int TRIG_LSB = 0;
  localparam logic [6:0] DEPTH_16 = 7'h10;
  localparam logic [6:0] DEPTH_32 = 7'h20;
  localparam logic [6:0] DEPTH_48 = 7'h30;
  localparam logic [6:0] DEPTH_64 = 7'h40;

  // Control register fields
  localparam int CTL_SET_SEL = 0;
  localparam int CTL_MODE_LSB = 1;
  localparam int CTL_MODE_MSB = 2;

  // Status bits
  localparam int IRQ_THRESH = 0;
  localparam int IRQ_SET_SWITCH = 1;
  localparam int IRQ_W = 2;

  typedef enum logic [1:0] {
    FSCR_MODE_STANDBY = 2'h0,
    FSCR_MODE_RX = 2'h1,
    FSCR_MODE_TX = 2'h2
  } fscr_mode_t;
endpackage : fscr_pkg

// >>> rtl/fscr_reg8.sv
module fscr_reg8 #(
  parameter logic [7:0] RESET_VALUE = 8'h00
) (
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic i_wr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_q
);
  logic [7:0] next_q;

  always_comb begin
    next_q = i_wr ? i_wdata : o_q;
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_q <= RESET_VALUE;
    end else begin
      o_q <= next_q;
    end
  end
endmodule : fscr_reg8

// >>> rtl/fscr_thresh.sv
module fscr_thresh
  import fscr_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic [1:0] i_mode,
  input wire logic [5:0] i_trigger,
  input wire logic [6:0] i_fill,
  output logic o_level
);
  logic next_level;

  // Transmit: FIFO drained down to the trigger. Receive and standby: filled past it.
  always_comb begin
    if (i_mode == FSCR_MODE_TX) begin
      next_level = i_fill <= {1'b0, i_trigger};
    end else begin
      next_level = i_fill > {1'b0, i_trigger};
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_level <= 1'b0;
    end else begin
      o_level <= next_level;
    end
  end
endmodule : fscr_thresh

// >>> testbench/fscr_regs_tb_top.sv
module fscr_regs_tb_top
  import fscr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {logic rd; logic [31:0] data; logic err;} fscr_exp_t;

  logic i_core_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic i_psel = 1'b0;
  logic i_penable = 1'b0;
  logic i_pwrite = 1'b0;
  logic [7:0] i_paddr = 8'h00;
  logic [31:0] i_pwdata = 32'h00000000;
  logic [6:0] i_fifo_fill = 7'h00;
  logic [31:0] o_prdata;
  logic o_pready, o_pslverr, o_synth_set_select, o_irq;
  logic [6:0] o_fifo_depth;
  logic [5:0] o_fifo_level_trigger;
  logic [7:0] o_synth_first_count, o_synth_second_count, o_synth_third_count;
  logic [1:0] o_mode;
  int err_count = 0;
  int num_checks = 0;
  logic [31:0] seed = 32'h00003D0D;
  fscr_exp_t exp_q[$];
  logic [7:0] set_a[3];
  logic [7:0] set_b[3];
  logic [7:0] idx_tab[7] = '{IDX_FIFO_SETUP, IDX_SET_A_FIRST, IDX_SET_A_SECOND, IDX_SET_A_THIRD,
    IDX_SET_B_FIRST, IDX_SET_B_SECOND, IDX_SET_B_THIRD};
  logic [7:0] rst_tab[7] = '{RST_FIFO_SETUP, RST_SET_A_FIRST, RST_SET_A_SECOND, RST_SET_A_THIRD,
    RST_SET_B_FIRST, RST_SET_B_SECOND, RST_SET_B_THIRD};

  fscr_regs dut (.i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
    .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .i_fifo_fill(i_fifo_fill), .o_fifo_depth(o_fifo_depth),
    .o_fifo_level_trigger(o_fifo_level_trigger), .o_synth_set_select(o_synth_set_select),
    .o_synth_first_count(o_synth_first_count), .o_synth_second_count(o_synth_second_count),
    .o_synth_third_count(o_synth_third_count), .o_mode(o_mode), .o_irq(o_irq));

  always #12.5 i_core_clk = ~i_core_clk;

  // ----------------------------------------
  // Checking and reporting
  // ----------------------------------------
  task automatic report_and_stop();
    if (err_count == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : report_and_stop

  task automatic fail_msg(input string msg);
    err_count++;
    $display("ERROR t=%0t %s", $time, msg);
  endtask : fail_msg

  task automatic check_val(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp) fail_msg($sformatf("%s got %h exp %h", what, got, exp));
  endtask : check_val

  task automatic check_rd();
    fscr_exp_t e;
    if (exp_q.size() == 0) begin
      fail_msg("unexpected bus transfer");
      return;
    end
    e = exp_q.pop_front();
    check_val(32'(o_pslverr), 32'(e.err), "pslverr");
    if (e.rd) check_val(o_prdata, e.data, "read data");
  endtask : check_rd

  // Reads settle on the access edge, so the note is taken off there
  always @(posedge i_core_clk) begin
    if (i_psel && i_penable && o_pready === 1'b1) check_rd();
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // ----------------------------------------
  // Bus and port helpers
  // ----------------------------------------
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
                     input logic [31:0] exp_data, input logic exp_err);
    @(posedge i_core_clk);
    i_psel <= 1'b1;
    i_pwrite <= wr;
    i_paddr <= addr;
    i_pwdata <= wdata;
    exp_q.push_back('{rd: !wr, data: exp_data, err: exp_err});
    @(posedge i_core_clk);
    i_penable <= 1'b1;
    // Only the watchdog ends a wait for ready
    do begin
      @(posedge i_core_clk);
    end while (o_pready !== 1'b1);
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    apb(1'b1, {idx[5:0], 2'b00}, d, 32'h0, 1'b0);
  endtask : wr

  task automatic rd(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b0, {idx[5:0], 2'b00}, 32'h0, 32'(d), 1'b0);
  endtask : rd

  task automatic settle(input int n);
    repeat (n) @(posedge i_core_clk);
    @(negedge i_core_clk);
  endtask : settle

  task automatic check_trio(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
    check_val(32'(o_synth_first_count), 32'(a), "first count");
    check_val(32'(o_synth_second_count), 32'(b), "second count");
    check_val(32'(o_synth_third_count), 32'(c), "third count");
  endtask : check_trio

  task automatic wait_irq(input logic exp);
    int n;
    n = 0;
    settle(0);
    while (o_irq !== exp && n < 8) begin
      settle(0);
      n++;
    end
    check_val(32'(o_irq), 32'(exp), "irq");
  endtask : wait_irq

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge i_core_clk);
    i_resetn <= 1'b1;
    settle(0);
    check_val(32'(o_fifo_depth), 32'(DEPTH_16), "depth");
    check_val(32'(o_fifo_level_trigger), 32'h0F, "trigger");
    check_trio(RST_SET_A_FIRST, RST_SET_A_SECOND, RST_SET_A_THIRD);
    foreach (idx_tab[i]) rd(idx_tab[i], rst_tab[i]);
    for (int i = 0; i < 3; i++) begin
      seed = lfsr(seed);
      set_a[i] = seed[7:0];
      set_b[i] = seed[7:0] ^ (seed[15:8] | 8'h01);
      wr(idx_tab[1 + i], 32'(set_a[i]));
      wr(idx_tab[4 + i], 32'(set_b[i]));
    end
    for (int i = 0; i < 3; i++) begin
      rd(idx_tab[1 + i], set_a[i]);
      rd(idx_tab[4 + i], set_b[i]);
    end
    settle(2);
    check_trio(set_a[0], set_a[1], set_a[2]);
    wr(IDX_CONTROL, 32'h1);
    // Every element of B differs from A, so a half-switched set shows up
    repeat (4) begin
      settle(0);
      num_checks++;
      if (!({o_synth_first_count, o_synth_second_count, o_synth_third_count} ===
            {set_a[0], set_a[1], set_a[2]} || {o_synth_first_count, o_synth_second_count,
            o_synth_third_count} === {set_b[0], set_b[1], set_b[2]})) fail_msg("mixed sets");
    end
    check_val(32'(o_synth_set_select), 32'h1, "select");
    check_trio(set_b[0], set_b[1], set_b[2]);
    set_a[0] = ~set_a[0];
    wr(IDX_SET_A_FIRST, 32'(set_a[0]));
    settle(2);
    check_trio(set_b[0], set_b[1], set_b[2]);
    wr(IDX_CONTROL, 32'h0);
    settle(2);
    check_trio(set_a[0], set_a[1], set_a[2]);
    rd(IDX_IRQ_STATUS, 8'h02);
    for (int c = 0; c < 4; c++) begin
      wr(IDX_FIFO_SETUP, 32'({c[1:0], 6'(c * 9 + 3)}));
      settle(2);
      check_val(32'(o_fifo_depth), 32'((c + 1) * 16), "depth");
      check_val(32'(o_fifo_level_trigger), 32'(c * 9 + 3), "trigger");
    end
    apb(1'b0, 8'h30, 32'h0, 32'h0, 1'b1);
    apb(1'b1, 8'h15, 32'hFF, 32'h0, 1'b1);
    rd(IDX_FIFO_SETUP, 8'hDE);
    // Trigger is now 30: standby fires above it, transmit at or below it
    wr(IDX_IRQ_MASK, 32'h1);
    wr(IDX_IRQ_STATUS, 32'h3);
    wait_irq(1'b0);
    @(posedge i_core_clk);
    i_fifo_fill <= 7'h28;
    wait_irq(1'b1);
    rd(IDX_FIFO_LEVEL, 8'h28);
    rd(IDX_IRQ_STATUS, 8'h01);
    wr(IDX_IRQ_STATUS, 32'h1);
    wr(IDX_CONTROL, 32'h4);
    wait_irq(1'b0);
    check_val(32'(o_mode), 32'(FSCR_MODE_TX), "mode");
    @(posedge i_core_clk);
    i_fifo_fill <= 7'h1E;
    wait_irq(1'b1);
    wr(IDX_IRQ_MASK, 32'h0);
    wait_irq(1'b0);
    wr(IDX_IRQ_STATUS, 32'h1);
    wr(IDX_CONTROL, 32'h2);
    rd(IDX_CONTROL, 8'h02);
    settle(3);
    rd(IDX_IRQ_STATUS, 8'h00);
    @(posedge i_core_clk);
    i_fifo_fill <= 7'h1F;
    settle(4);
    rd(IDX_IRQ_STATUS, 8'h01);
    @(posedge i_core_clk);
    i_resetn <= 1'b0;
    settle(1);
    check_trio(RST_SET_A_FIRST, RST_SET_A_SECOND, RST_SET_A_THIRD);
    report_and_stop();
  end

  initial begin
    #(25 * 4000);
    fail_msg("timeout");
    report_and_stop();
  end
endmodule : fscr_regs_tb_top
